/* usc_top.sv */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module usc_top
  import usc_pkg::*;
#(
  parameter int DEPTH = usc_pkg::USC_FIFO_DEPTH
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  input  wire logic        serial_rx_in,
  output logic             serial_tx_pin_out,
  output logic             serial_tx_pin_oe_out,
  output logic             rx_irq_out,
  output logic             rx_address_out
);
  import usc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Software state
  logic        tx_idle_invert;         // Idle polarity select
  logic        tx_break_request;       // Break pending
  logic        tx_enable_bit;          // Transmitter on
  logic [1:0]  rx_irq_select;          // Receive interrupt mode
  logic        address_detect_enable;  // Address filtering
  logic        overrun_error_flag;     // Sticky overrun
  logic [1:0]  parity_data_select;     // Format select
  logic        infrared_codec_enable;  // Infrared encoding
  logic [15:0] baud_div;               // Clocks per bit minus one

  wire wr_sta  = reg_wr_in && (reg_addr_in == USC_ADDR_STA);
  wire wr_tx   = reg_wr_in && (reg_addr_in == USC_ADDR_TXDATA);
  wire rd_rx   = reg_rd_in && (reg_addr_in == USC_ADDR_RXDATA);
  wire nine_bit = (parity_data_select == USC_PARITY_DATA_SELECT_9BIT);
  wire overrun_error_flag_clr = wr_sta && overrun_error_flag && !reg_wdata_in[USC_B_OVERRUN_ERROR_FLAG];

  //////////////////////////////////////////////////////////////////////////
  // Queues
  logic [8:0]  txq_head;
  logic [$clog2(DEPTH):0] txq_cnt;
  logic [10:0] rxq_head;
  logic [$clog2(DEPTH):0] rxq_cnt;
  logic        tx_pop;
  logic        rx_push;
  logic [10:0] rx_word;
  wire tx_buffer_full = (txq_cnt == ($clog2(DEPTH)+1)'(DEPTH));
  wire rx_full        = (rxq_cnt == ($clog2(DEPTH)+1)'(DEPTH));

  // Transmit queue, flushed while the transmitter is off
  usc_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_txq (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .flush_in     (!tx_enable_bit),
    .push_in      (wr_tx && tx_enable_bit),
    .push_data_in (reg_wdata_in[8:0]),
    .pop_in       (tx_pop),
    .head_out     (txq_head),
    .count_out    (txq_cnt)
  );

  // Receive queue, entry = {parity err, framing err, data[8:0]}
  usc_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rxq (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .flush_in     (overrun_error_flag_clr),
    .push_in      (rx_push && !rx_full),
    .push_data_in (rx_word),
    .pop_in       (rd_rx),
    .head_out     (rxq_head),
    .count_out    (rxq_cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register writes and hardware-updated flags
  logic brk_done;  // Break frame finished
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_idle_invert        <= 1'b0;
      tx_break_request      <= 1'b0;
      tx_enable_bit         <= 1'b0;
      rx_irq_select         <= 2'h0;
      address_detect_enable <= 1'b0;
      parity_data_select    <= 2'h0;
      infrared_codec_enable <= 1'b0;
      baud_div              <= USC_BAUD_RST;
    end else begin
      if (wr_sta) begin
        tx_idle_invert        <= reg_wdata_in[USC_B_TXINV];
        tx_enable_bit         <= reg_wdata_in[USC_B_TXEN];
        rx_irq_select         <= reg_wdata_in[USC_B_RXSEL +: 2];
        address_detect_enable <= reg_wdata_in[USC_B_ADDRESS_DETECT_ENABLE];
      end
      // Hardware clear on completion; disable also drops it
      if (wr_sta && reg_wdata_in[USC_B_BRK] && reg_wdata_in[USC_B_TXEN])
        tx_break_request <= 1'b1;
      else if (brk_done || (wr_sta && !reg_wdata_in[USC_B_BRK]) || !tx_enable_bit)
        tx_break_request <= 1'b0;
      if (reg_wr_in && reg_addr_in == USC_ADDR_CFG) begin
        parity_data_select    <= reg_wdata_in[USC_B_PARITY_DATA_SELECT +: 2];
        infrared_codec_enable <= reg_wdata_in[USC_B_INFRARED_CODEC_ENABLE];
      end
      if (reg_wr_in && reg_addr_in == USC_ADDR_BAUD) baud_div <= reg_wdata_in;
    end
  end

  // Overrun: set wins, software may only clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) overrun_error_flag <= 1'b0;
    else if (rx_push && rx_full) overrun_error_flag <= 1'b1;
    else if (overrun_error_flag_clr) overrun_error_flag <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  usc_tx_e     tx_state;
  logic [15:0] tx_tick;   // Bit-time counter
  logic [3:0]  tx_bit;    // Bit index within frame
  logic [11:0] tx_frame;  // Start, data, parity, stop bits
  logic [3:0]  tx_len;    // Bits in frame
  logic        tx_level;  // Raw line level
  wire tx_tick_end = (tx_tick == baud_div);
  wire tx_par = ^txq_head[7:0] ^ (parity_data_select == USC_PARITY_DATA_SELECT_ODD);
  assign tx_pop = (tx_state == USC_TX_IDLE) && tx_enable_bit && !tx_break_request
                  && (txq_cnt != '0);
  wire brk_start = (tx_state == USC_TX_IDLE) && tx_break_request;
  assign brk_done = (tx_state == USC_TX_BREAK) && tx_tick_end
                    && (tx_bit == 4'(USC_BRK_ZEROS + 1));

  // Frame sequencer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_state <= USC_TX_IDLE;
      tx_tick  <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_frame <= 12'hfff;
      tx_len   <= 4'h0;
    end else if (!tx_enable_bit) begin
      tx_state <= USC_TX_IDLE;
      tx_frame <= 12'hfff;
    end else begin
      case (tx_state)
        USC_TX_IDLE: begin
          tx_tick <= 16'h0000;
          tx_bit  <= 4'h0;
          if (brk_start) begin
            tx_state <= USC_TX_BREAK;
          end else if (tx_pop) begin
            tx_state <= USC_TX_SHIFT;
            if (nine_bit) begin
              tx_frame <= {1'b1, 1'b1, txq_head[8:0], 1'b0};
              tx_len   <= 4'd11;
            end else if (parity_data_select == 2'h0) begin
              tx_frame <= {2'b11, 1'b1, txq_head[7:0], 1'b0};
              tx_len   <= 4'd10;
            end else begin
              tx_frame <= {1'b1, 1'b1, tx_par, txq_head[7:0], 1'b0};
              tx_len   <= 4'd11;
            end
          end
        end
        USC_TX_SHIFT, USC_TX_BREAK: begin
          tx_tick <= tx_tick_end ? 16'h0000 : tx_tick + 16'h0001;
          if (tx_tick_end) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_state == USC_TX_SHIFT) tx_frame <= {1'b1, tx_frame[11:1]};
            if ((tx_state == USC_TX_SHIFT && tx_bit == tx_len - 4'h1) || brk_done)
              tx_state <= USC_TX_IDLE;
          end
        end
        default: tx_state <= USC_TX_IDLE;
      endcase
    end
  end

  // Break holds low through start and twelve zeros, then stop high
  always_comb begin
    case (tx_state)
      USC_TX_SHIFT: tx_level = tx_frame[0];
      USC_TX_BREAK: tx_level = (tx_bit > 4'(USC_BRK_ZEROS));
      default:      tx_level = 1'b1;
    endcase
  end

  // Pin drive with polarity and infrared pulse shaping
  wire ir_pulse = (tx_tick < {2'b00, baud_div[15:2]});
  wire tx_ir    = !tx_level && ir_pulse;  // Pulse marks a zero bit
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_tx_pin_out    <= 1'b0;
      serial_tx_pin_oe_out <= 1'b0;
    end else begin
      serial_tx_pin_oe_out <= tx_enable_bit;
      if (infrared_codec_enable)
        serial_tx_pin_out <= tx_ir ^ tx_idle_invert;
      else
        serial_tx_pin_out <= tx_level ^ tx_idle_invert;
    end
  end
  wire tx_shift_empty = (tx_state == USC_TX_IDLE) && (txq_cnt == '0);

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  logic        rx_busy;
  logic [15:0] rx_tick;
  logic [3:0]  rx_bit;
  logic [10:0] rx_sr;    // Receive shift register
  wire [3:0] rx_len  = (parity_data_select == 2'h0) ? 4'd9 : 4'd10;
  wire rx_tick_end   = (rx_tick == baud_div);
  wire rx_mid        = (rx_tick == {1'b0, baud_div[15:1]});
  wire rx_last       = rx_busy && rx_mid && (rx_bit == rx_len);
  wire [8:0] rx_nine = rx_sr[10:2];  // Nine data bits above the start sample
  wire [8:0] rx_data = nine_bit ? rx_nine
                       : (parity_data_select == 2'h0 ? {1'b0, rx_sr[10:3]}
                                                     : {1'b0, rx_sr[9:2]});
  wire rx_parity_error_flag = !nine_bit && (parity_data_select != 2'h0)
                 && ((^rx_sr[10:2]) != (parity_data_select == USC_PARITY_DATA_SELECT_ODD));
  wire rx_framing_error_flag = !serial_rx_in;  // Stop bit sampled low
  wire rx_is_addr = nine_bit && rx_data[8];
  wire rx_keep = !(address_detect_enable && nine_bit) || rx_is_addr;
  assign rx_push = rx_last && rx_keep;
  assign rx_word = {rx_parity_error_flag, rx_framing_error_flag, rx_data};

  // Bit sampler; overrun clear also empties the shift register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_busy <= 1'b0;
      rx_tick <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_sr   <= 11'h000;
    end else if (overrun_error_flag_clr) begin
      rx_busy <= 1'b0;
      rx_sr   <= 11'h000;
    end else if (!rx_busy) begin
      rx_tick <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_busy <= !serial_rx_in;  // Start edge
    end else begin
      rx_tick <= rx_tick_end ? 16'h0000 : rx_tick + 16'h0001;
      if (rx_mid) begin
        rx_bit <= rx_bit + 4'h1;
        rx_sr  <= {serial_rx_in, rx_sr[10:1]};
        if (rx_bit == 4'h0 && serial_rx_in) rx_busy <= 1'b0;  // False start
        if (rx_last) rx_busy <= 1'b0;
      end
    end
  end

  // Receive interrupt and address pulses
  wire [$clog2(DEPTH):0] rx_next = rxq_cnt + ($clog2(DEPTH)+1)'(1);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_irq_out     <= 1'b0;
      rx_address_out <= 1'b0;
    end else begin
      rx_address_out <= rx_push && !rx_full && rx_is_addr;
      case (rx_irq_select)
        2'h3: rx_irq_out <= rx_push && !rx_full && (rx_next == 3'(4));
        2'h2: rx_irq_out <= rx_push && !rx_full && (rx_next == 3'(3));
        default: rx_irq_out <= rx_push && !rx_full;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [15:0] sta_word;
  always_comb begin
    sta_word = 16'h0000;  // Unimplemented bits read zero
    sta_word[USC_B_TXINV]      = tx_idle_invert;
    sta_word[USC_B_BRK]        = tx_break_request;
    sta_word[USC_B_TXEN]       = tx_enable_bit;
    sta_word[USC_B_TXBF]       = tx_buffer_full;
    sta_word[USC_B_TX_SHIFT_EMPTY]       = tx_shift_empty;
    sta_word[USC_B_RXSEL +: 2] = rx_irq_select;
    sta_word[USC_B_ADDRESS_DETECT_ENABLE]      = address_detect_enable;
    sta_word[USC_B_RX_IDLE_FLAG]      = !rx_busy;
    sta_word[USC_B_PARITY_ERROR_FLAG]       = (rxq_cnt != '0) && rxq_head[10];
    sta_word[USC_B_FRAMING_ERROR_FLAG]       = (rxq_cnt != '0) && rxq_head[9];
    sta_word[USC_B_OVERRUN_ERROR_FLAG]       = overrun_error_flag;
    sta_word[USC_B_RXDA]       = (rxq_cnt != '0);
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) reg_rdata_out <= 16'h0000;
    else if (reg_rd_in) begin
      case (reg_addr_in)
        USC_ADDR_STA:    reg_rdata_out <= sta_word;
        USC_ADDR_RXDATA: reg_rdata_out <= {7'h00, rxq_head[8:0]};
        USC_ADDR_CFG:    reg_rdata_out <= {12'h000, infrared_codec_enable,
                                           parity_data_select, 1'b0};
        USC_ADDR_BAUD:   reg_rdata_out <= baud_div;
        default:         reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_tx_shift_empty_empty: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_tx && tx_enable_bit && !tx_buffer_full) |=> !sta_word[USC_B_TX_SHIFT_EMPTY])
    else $error("shift-empty set while busy");
  a_overrun_error_flag_flush: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (overrun_error_flag_clr && !(rx_push && rx_full)) |=> (rxq_cnt == '0 && !overrun_error_flag))
    else $error("overrun clear did not empty buffer");
  a_txen_off: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !tx_enable_bit |=> (!serial_tx_pin_oe_out && txq_cnt == '0))
    else $error("transmit disable not honoured");
  a_overrun_error_flag_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rx_push && rx_full) |=> overrun_error_flag)
    else $error("overrun not flagged");
  a_rxda_cnt: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rx_push && !rx_full && !overrun_error_flag_clr) |=> sta_word[USC_B_RXDA])
    else $error("data-available mismatch");
  a_txbf_full: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_tx && tx_enable_bit && !tx_buffer_full && !tx_pop) |=> (txq_cnt == $past(txq_cnt) + 1'b1))
    else $error("buffer not-full yet write lost");
  a_irq_four: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rx_irq_out && rx_irq_select == 2'h3) |-> (rxq_cnt == 3'(4)))
    else $error("full interrupt at wrong level");
  a_brk_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    brk_done |=> !tx_break_request)
    else $error("break request not cleared");
endmodule // usc_top

/* usc_pkg.sv */
package usc_pkg;
  // Register map (word indices on the plain register port)
  localparam logic [2:0] USC_ADDR_STA    = 3'h0;  // Status and control
  localparam logic [2:0] USC_ADDR_TXDATA = 3'h1;  // Transmit character write
  localparam logic [2:0] USC_ADDR_RXDATA = 3'h2;  // Receive character read
  localparam logic [2:0] USC_ADDR_CFG    = 3'h3;  // Line configuration
  localparam logic [2:0] USC_ADDR_BAUD   = 3'h4;  // Bit period in clocks minus one
  // Status and control field positions
  localparam int USC_B_TXINV  = 14;
  localparam int USC_B_BRK    = 11;
  localparam int USC_B_TXEN   = 10;
  localparam int USC_B_TXBF   = 9;
  localparam int USC_B_TX_SHIFT_EMPTY   = 8;
  localparam int USC_B_RXSEL  = 6;
  localparam int USC_B_ADDRESS_DETECT_ENABLE  = 5;
  localparam int USC_B_RX_IDLE_FLAG  = 4;
  localparam int USC_B_PARITY_ERROR_FLAG   = 3;
  localparam int USC_B_FRAMING_ERROR_FLAG   = 2;
  localparam int USC_B_OVERRUN_ERROR_FLAG   = 1;
  localparam int USC_B_RXDA   = 0;
  // Configuration register fields
  localparam int USC_B_PARITY_DATA_SELECT  = 1;  // Two bits, 11 = nine data bits
  localparam int USC_B_INFRARED_CODEC_ENABLE   = 3;
  // Reset value and other constants
  localparam logic [15:0] USC_BAUD_RST = 16'h000f;
  localparam logic [1:0]  USC_PARITY_DATA_SELECT_9BIT = 2'h3;
  localparam logic [1:0]  USC_PARITY_DATA_SELECT_ODD  = 2'h2;
  localparam logic [1:0]  USC_PARITY_DATA_SELECT_EVEN = 2'h1;
  localparam int USC_FIFO_DEPTH = 4;
  localparam int USC_BRK_ZEROS  = 12;
  // Transmitter states
  typedef enum logic [1:0] {
    USC_TX_IDLE  = 2'b00,
    USC_TX_SHIFT = 2'b01,
    USC_TX_BREAK = 2'b10
  } usc_tx_e;
endpackage

/* usc_fifo.sv */
`timescale 1ns/10ps
// Small first-in first-out queue with flush
module usc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  input  wire logic             flush_in,
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  input  wire logic             pop_in,
  output logic [WIDTH-1:0]      head_out,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0]    rd_ptr;       // Head index
  logic [AW-1:0]    wr_ptr;       // Tail index
  wire do_push = push_in && (count_out != (AW+1)'(DEPTH));
  wire do_pop  = pop_in && (count_out != '0);

  assign head_out = mem[rd_ptr];

  // Pointer and count upkeep
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_ptr    <= '0;
      wr_ptr    <= '0;
      count_out <= '0;
    end else if (flush_in) begin
      rd_ptr    <= '0;
      wr_ptr    <= '0;
      count_out <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      count_out <= count_out + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (do_push && !flush_in) mem[wr_ptr] <= push_data_in;
  end
endmodule // usc_fifo

/* usc_remote.sv */
`timescale 1ns/10ps
// Far-side serial device: sends frames on request and listens on the line
module usc_remote #(
  parameter int CPB = 8  // Clocks per bit in both directions
) (
  input  wire logic        clk_sys_in,
  input  wire logic        send_in,         // Start one frame
  input  wire logic [11:0] frame_in,        // Frame bits, first bit in bit 0
  input  wire logic [3:0]  len_in,          // Number of frame bits
  input  wire logic        tx_line_in,      // Device transmit line, pulled up
  output logic             line_out,        // Line into the device receiver
  output logic             busy_out,        // Frame in flight
  output logic [7:0]       char_out,        // Last character heard
  output logic             char_valid_out,  // One-cycle pulse per character
  output logic [15:0]      low_len_out,     // Clocks of the last low stretch
  output logic             rise_out         // Pulse as a low stretch ends
);
  logic [15:0] low_cnt = 16'h0000;  // Running low stretch
  logic [9:0]  sh;                  // Sampled bits of a heard frame
  logic [11:0] fr;                  // Frame latched at request
  logic [3:0]  fl;                  // Length latched at request
  // Sender: idle high between frames, every bit held for CPB clocks
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_sys_in);
      if (send_in === 1'b1) begin
        fr = frame_in;
        fl = len_in;
        busy_out <= 1'b1;
        for (int i = 0; i < fl; i++) begin
          line_out <= fr[i];
          repeat (CPB) @(posedge clk_sys_in);
        end
        line_out <= 1'b1;
        busy_out <= 1'b0;
      end
    end
  end
  // Listener: start, eight data bits, stop, sampled mid bit
  initial begin
    char_out = 8'h00;
    char_valid_out = 1'b0;
    forever begin
      @(negedge tx_line_in);
      repeat (CPB / 2) @(posedge clk_sys_in);
      for (int i = 0; i < 10; i++) begin
        sh[i] = tx_line_in;
        if (i < 9) repeat (CPB) @(posedge clk_sys_in);
      end
      char_out <= sh[8:1];
      char_valid_out <= 1'b1;
      @(posedge clk_sys_in);
      char_valid_out <= 1'b0;
    end
  end
  // Measures each low stretch, used to time a break
  always @(posedge clk_sys_in) begin
    rise_out <= 1'b0;
    if (tx_line_in === 1'b0) begin
      low_cnt <= low_cnt + 16'h0001;
    end else begin
      if (low_cnt != 16'h0000) begin
        low_len_out <= low_cnt;
        rise_out <= 1'b1;
      end
      low_cnt <= 16'h0000;
    end
  end
endmodule // usc_remote

/* tb_top.sv */
`timescale 1ns/10ps
// Bench: drives the register port and a far-side serial device
module tb_top;
  import usc_pkg::*;
  localparam int          CPB  = 8;                       // Clocks per bit
  localparam logic [15:0] TXEN = 16'h0001 << USC_B_TXEN;  // Transmit enable
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [2:0]  reg_addr   = 3'h0;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        send       = 1'b0;
  logic [11:0] frame      = 12'h000;
  logic [3:0]  flen       = 4'h0;
  logic [15:0] reg_rdata, low_len, st;
  logic [7:0]  char_rx;
  logic        serial_rx, tx_pin, tx_oe, rx_irq, rx_addr, tx_line, busy, char_valid, rise;
  int          err_count = 0;
  int          checks    = 0;
  int          irq_n     = 0;
  int          addr_n    = 0;
  logic [7:0]  heard[$];  // Characters heard by the far side
  assign tx_line = tx_oe ? tx_pin : 1'b1;  // Pull-up while the pin is released
  initial forever #20 clk_sys_in = ~clk_sys_in;
  // Counts pulses and collects heard characters
  always @(posedge clk_sys_in) begin
    if (rx_irq === 1'b1) irq_n++;
    if (rx_addr === 1'b1) addr_n++;
    if (char_valid === 1'b1) heard.push_back(char_rx);
  end
  usc_top dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .serial_rx_in(serial_rx), .serial_tx_pin_out(tx_pin),
    .serial_tx_pin_oe_out(tx_oe), .rx_irq_out(rx_irq), .rx_address_out(rx_addr));
  usc_remote #(.CPB(CPB)) far (.clk_sys_in(clk_sys_in), .send_in(send), .frame_in(frame),
    .len_in(flen), .tx_line_in(tx_line), .line_out(serial_rx), .busy_out(busy),
    .char_out(char_rx), .char_valid_out(char_valid), .low_len_out(low_len), .rise_out(rise));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      err_count++;
      $display("[ERR] wait expected done seen timeout");
      end_sim();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Reads status and compares one bit
  task automatic sbit(input string what, input int b, input logic e);
    logic [15:0] s;
    rd(USC_ADDR_STA, s);
    chk(what, {15'h0000, e}, {15'h0000, s[b]});
  endtask
  function automatic logic [11:0] c8(input logic [7:0] d);
    return {3'b001, d, 1'b0};
  endfunction
  // Far side sends one frame; returns once it has landed
  task automatic send_frame(input logic [11:0] f, input logic [3:0] n);
    int k;
    @(posedge clk_sys_in);
    frame <= f;
    flen <= n;
    send <= 1'b1;
    @(posedge clk_sys_in);
    send <= 1'b0;
    for (k = 0; k < 200; k++) begin
      #1;
      if (busy === 1'b0) break;
      @(posedge clk_sys_in);
    end
    tmo(k, 200);
    repeat (4) @(posedge clk_sys_in);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_tx();
    int k;
    rd(USC_ADDR_STA, st);
    chk("status", 16'h0110, st);
    wr(USC_ADDR_STA, 16'h1000);
    rd(USC_ADDR_STA, st);
    chk("status", 16'h0110, st);
    rd(3'h5, st);
    chk("unmapped", 16'h0000, st);
    wr(USC_ADDR_BAUD, 16'(CPB - 1));
    wr(USC_ADDR_STA, TXEN);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("oe", 16'h0001, {15'h0, tx_oe});
    heard.delete();
    for (k = 0; k < 5; k++) wr(USC_ADDR_TXDATA, 16'h0030 + k[15:0]);
    sbit("txbf", USC_B_TXBF, 1'b1);
    sbit("tx_shift_empty", USC_B_TX_SHIFT_EMPTY, 1'b0);
    wr(USC_ADDR_TXDATA, 16'h0077);
    for (k = 0; k < 400; k++) begin
      rd(USC_ADDR_STA, st);
      if (st[USC_B_TX_SHIFT_EMPTY] === 1'b1) break;
    end
    tmo(k, 400);
    sbit("txbf", USC_B_TXBF, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("heard", 16'h0005, 16'(heard.size()));
    foreach (heard[i]) chk("char", 16'h0030 + 16'(i), {8'h00, heard[i]});
    for (k = 0; k < 3; k++) wr(USC_ADDR_TXDATA, 16'h0041 + k[15:0]);
    repeat (20) @(posedge clk_sys_in);
    wr(USC_ADDR_STA, 16'h0000);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("oe", 16'h0000, {15'h0, tx_oe});
    sbit("tx_shift_empty", USC_B_TX_SHIFT_EMPTY, 1'b1);
    repeat (200) @(posedge clk_sys_in);
    wr(USC_ADDR_STA, TXEN);
    repeat (100) @(posedge clk_sys_in);
    sbit("tx_shift_empty", USC_B_TX_SHIFT_EMPTY, 1'b1);
    $display("test transmit done");
  endtask
  task automatic t_break_ir();
    int k;
    wr(USC_ADDR_STA, TXEN | (16'h0001 << USC_B_BRK));
    wr(USC_ADDR_TXDATA, 16'h0000);
    for (k = 0; k < 400; k++) begin
      @(posedge clk_sys_in);
      #1;
      if (rise === 1'b1) break;
    end
    tmo(k, 400);
    chk("break low", 16'(13 * CPB), low_len);
    repeat (2 * CPB) @(posedge clk_sys_in);
    sbit("brk", USC_B_BRK, 1'b0);
    repeat (300) @(posedge clk_sys_in);
    wr(USC_ADDR_CFG, 16'h0001 << USC_B_INFRARED_CODEC_ENABLE);
    wr(USC_ADDR_STA, TXEN | (16'h0001 << USC_B_TXINV));
    repeat (4) @(posedge clk_sys_in);
    #1 chk("ir idle", 16'h0001, {15'h0, tx_pin});
    wr(USC_ADDR_STA, TXEN);
    repeat (4) @(posedge clk_sys_in);
    #1 chk("ir idle", 16'h0000, {15'h0, tx_pin});
    wr(USC_ADDR_CFG, 16'h0000);
    wr(USC_ADDR_STA, 16'h0000);
    repeat (100) @(posedge clk_sys_in);
    $display("test break done");
  endtask
  task automatic t_rx();
    int s, k, n0;
    for (s = 0; s < 4; s++) begin
      wr(USC_ADDR_STA, (16'(s) << USC_B_RXSEL) | 16'h0002);
      sbit("overrun_error_flag", USC_B_OVERRUN_ERROR_FLAG, 1'b0);
      for (k = 1; k <= (s < 2 ? 1 : s + 1); k++) begin
        n0 = irq_n;
        fork
          send_frame(c8(8'h10 + k[7:0]), 4'ha);
          begin
            repeat (3 * CPB) @(posedge clk_sys_in);
            sbit("rx_idle_flag", USC_B_RX_IDLE_FLAG, 1'b0);
          end
        join
        chk("irq", {15'h0, s < 2 || k == s + 1}, 16'(irq_n - n0));
      end
      sbit("rxda", USC_B_RXDA, 1'b1);
      sbit("rx_idle_flag", USC_B_RX_IDLE_FLAG, 1'b1);
      if (s == 3) begin
        send_frame(c8(8'h1f), 4'ha);
        sbit("overrun_error_flag", USC_B_OVERRUN_ERROR_FLAG, 1'b1);
        wr(USC_ADDR_STA, 16'(s) << USC_B_RXSEL);
        sbit("rxda", USC_B_RXDA, 1'b0);
        sbit("overrun_error_flag", USC_B_OVERRUN_ERROR_FLAG, 1'b0);
      end else begin
        for (k = 1; k <= (s < 2 ? 1 : s + 1); k++) begin
          rd(USC_ADDR_RXDATA, st);
          chk("rx char", 16'h0010 + k[15:0], {7'h00, st[8:0]});
        end
        sbit("rxda", USC_B_RXDA, 1'b0);
      end
    end
    $display("test receive done");
  endtask
  task automatic t_err_addr();
    int a0;
    wr(USC_ADDR_STA, 16'h0000);
    send_frame({3'b000, 8'h5a, 1'b0}, 4'ha);
    send_frame(c8(8'h5b), 4'ha);
    sbit("framing_error_flag", USC_B_FRAMING_ERROR_FLAG, 1'b1);
    rd(USC_ADDR_RXDATA, st);
    sbit("framing_error_flag", USC_B_FRAMING_ERROR_FLAG, 1'b0);
    rd(USC_ADDR_RXDATA, st);
    wr(USC_ADDR_CFG, 16'(USC_PARITY_DATA_SELECT_EVEN) << USC_B_PARITY_DATA_SELECT);
    send_frame({2'b01, 1'b0, 8'h07, 1'b0}, 4'hb);
    send_frame({2'b01, 1'b0, 8'h03, 1'b0}, 4'hb);
    sbit("parity_error_flag", USC_B_PARITY_ERROR_FLAG, 1'b1);
    rd(USC_ADDR_RXDATA, st);
    sbit("parity_error_flag", USC_B_PARITY_ERROR_FLAG, 1'b0);
    rd(USC_ADDR_RXDATA, st);
    wr(USC_ADDR_CFG, 16'(USC_PARITY_DATA_SELECT_9BIT) << USC_B_PARITY_DATA_SELECT);
    wr(USC_ADDR_STA, 16'h0001 << USC_B_ADDRESS_DETECT_ENABLE);
    a0 = addr_n;
    send_frame({2'b01, 9'h155, 1'b0}, 4'hb);
    send_frame({2'b01, 9'h055, 1'b0}, 4'hb);
    chk("addr", 16'h0001, 16'(addr_n - a0));
    rd(USC_ADDR_RXDATA, st);
    chk("rx char", 16'h0155, {7'h00, st[8:0]});
    sbit("rxda", USC_B_RXDA, 1'b0);
    wr(USC_ADDR_CFG, 16'h0000);
    send_frame(c8(8'h3c), 4'ha);
    chk("addr", 16'h0001, 16'(addr_n - a0));
    rd(USC_ADDR_RXDATA, st);
    chk("rx char", 16'h003c, {7'h00, st[8:0]});
    $display("test errors and address done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_tx();
    t_break_ir();
    t_rx();
    t_err_addr();
    end_sim();
  end
endmodule // tb_top
